// ===== verilog/rpces_defines.svh
// Register map, field layout, reset values and timing constants of the receive port error block
`ifndef RPCES_DEFINES_SVH
`define RPCES_DEFINES_SVH
// Register addresses
`define RPCES_ADDR_PORT_SEL 8'h4C
`define RPCES_ADDR_CLK_DET 8'h77
`define RPCES_ADDR_MSG_A 8'h78
`define RPCES_ADDR_MSG_B 8'h79
`define RPCES_ADDR_ERR_FLAGS 8'h7A
`define RPCES_ADDR_ERR_TALLY 8'h7B
// Reset values
`define RPCES_RST_PORT_SEL 8'h00
`define RPCES_RST_CLK_DET 8'hC5
`define RPCES_RST_MSG_A 8'h00
`define RPCES_RST_MSG_B 8'h01
`define RPCES_RST_ERR_FLAGS 4'h0
`define RPCES_RST_ERR_TALLY 8'h00
`define RPCES_RD_UNMAPPED 8'h00
`define RPCES_RSVD_ZERO 4'h0
// Field positions in clock_detect_control
`define RPCES_HYST_MSB 7
`define RPCES_HYST_LSB 6
`define RPCES_STAB_MSB 5
`define RPCES_STAB_LSB 4
`define RPCES_LOW_MSB 3
`define RPCES_LOW_LSB 0
// Bit positions in packet_error_flags
`define RPCES_FLAG_LEN 3
`define RPCES_FLAG_CKSUM 2
`define RPCES_FLAG_MULTI 1
`define RPCES_FLAG_SINGLE 0
// Stability times and clock rate
`define RPCES_CLK_MHZ 50
`define RPCES_US_PER_MS 1000
`define RPCES_STAB0_US 40
`define RPCES_STAB1_US 80
`define RPCES_STAB2_US 320
`define RPCES_STAB3_MS 1.28
`endif

// ===== verilog/rpces_pkg.sv
// Shared types of the receive port error block
`default_nettype none
package rpces_pkg;
    typedef logic [7:0] rpces_byte_t;
    typedef logic [3:0] rpces_flags_t;
endpackage
`default_nettype wire

// ===== verilog/rpces_err_if.sv
// Carrier between the register bank and the error tracker
`default_nettype none
interface rpces_err_if #(parameter int NUM_PORTS = 2);
    rpces_pkg::rpces_flags_t [NUM_PORTS-1:0] errEvent;
    logic [NUM_PORTS-1:0] pktEnd;
    logic [NUM_PORTS-1:0] clrFlags;
    logic [NUM_PORTS-1:0] clrTally;
    rpces_pkg::rpces_flags_t [NUM_PORTS-1:0] flags;
    rpces_pkg::rpces_byte_t [NUM_PORTS-1:0] tally;
    logic [NUM_PORTS-1:0] fixHeader;
    modport track (input errEvent, pktEnd, clrFlags, clrTally, output flags, tally, fixHeader);
    modport bank (output errEvent, pktEnd, clrFlags, clrTally, input flags, tally, fixHeader);
endinterface
`default_nettype wire

// ===== verilog/rpces_freq_detect.sv
// Per-port clock frequency hysteresis capture, stability timer and low limit check
`include "rpces_defines.svh"
`default_nettype none
module rpces_freq_detect #(
    parameter int CNT_W = 17,
    parameter int STAB_CYC0 = 2000,
    parameter int STAB_CYC1 = 4000,
    parameter int STAB_CYC2 = 16000,
    parameter int STAB_CYC3 = 64000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire rpces_pkg::rpces_byte_t measured,
    input wire logic measValid,
    input wire logic [1:0] hyst,
    input wire logic [1:0] stabSel,
    input wire logic [3:0] lowLimit,
    output logic stable,
    output logic tooLow
);
    rpces_pkg::rpces_byte_t heldFreq_reg;
    rpces_pkg::rpces_byte_t diff;
    logic [CNT_W-1:0] timer_reg;
    logic [CNT_W-1:0] target;
    logic capture;

    // Distance from the held value and target time for the chosen window
    always_comb begin
        diff = (measured >= heldFreq_reg) ? measured - heldFreq_reg : heldFreq_reg - measured;
        capture = measValid && (diff > {6'h00, hyst});
        unique case (stabSel)
            2'b00: target = CNT_W'(STAB_CYC0);
            2'b01: target = CNT_W'(STAB_CYC1);
            2'b10: target = CNT_W'(STAB_CYC2);
            2'b11: target = CNT_W'(STAB_CYC3);
        endcase
    end

    // Held measurement changes only beyond the hysteresis band
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            heldFreq_reg <= 8'h00;
        end else if (capture) begin
            heldFreq_reg <= measured;
        end
    end

    // Stability timer restarts on every captured change
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            timer_reg <= '0;
            stable <= 1'b0;
        end else if (capture) begin
            timer_reg <= '0;
            stable <= 1'b0;
        end else if (timer_reg >= target) begin
            stable <= 1'b1;
        end else begin
            timer_reg <= timer_reg + 1'b1;
        end
    end

    // Too-low judgement against the limit in MHz
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tooLow <= 1'b0;
        end else begin
            tooLow <= heldFreq_reg < {4'h0, lowLimit};
        end
    end
endmodule
`default_nettype wire

// ===== verilog/rpces_err_track.sv
// Per-port sticky packet error flags, saturating error tally and header fix strobe
`include "rpces_defines.svh"
`default_nettype none
module rpces_err_track #(
    parameter int NUM_PORTS = 2
) (
    input wire logic clock,
    input wire logic rst_n,
    rpces_err_if.track errBus
);
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : gPort
            logic pending_reg;
            logic bad;
            logic inc;
            assign bad = |errBus.errEvent[p];
            assign inc = errBus.pktEnd[p] && (pending_reg || bad);

            // Sticky flags; a new event wins over the clearing read
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    errBus.flags[p] <= `RPCES_RST_ERR_FLAGS;
                end else begin
                    errBus.flags[p] <= (errBus.clrFlags[p] ? `RPCES_RST_ERR_FLAGS : errBus.flags[p])
                        | errBus.errEvent[p];
                end
            end

            // Remembers an error seen anywhere in the current packet
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    pending_reg <= 1'b0;
                end else if (errBus.pktEnd[p]) begin
                    pending_reg <= 1'b0;
                end else if (bad) begin
                    pending_reg <= 1'b1;
                end
            end

            // Errored packet count, cleared by read, saturating
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    errBus.tally[p] <= `RPCES_RST_ERR_TALLY;
                end else if (errBus.clrTally[p]) begin
                    errBus.tally[p] <= {7'h00, inc};
                end else if (inc && (errBus.tally[p] != 8'hFF)) begin
                    errBus.tally[p] <= errBus.tally[p] + 8'h01;
                end
            end

            // Single-bit header errors are fixed; multi-bit ones are left alone
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    errBus.fixHeader[p] <= 1'b0;
                end else begin
                    errBus.fixHeader[p] <= errBus.errEvent[p][`RPCES_FLAG_SINGLE]
                        && !errBus.errEvent[p][`RPCES_FLAG_MULTI];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== verilog/rx_port_csi_error_status.sv
// Port-selected register bank for clock detect settings, scratch messages and CSI error status
`include "rpces_defines.svh"
`default_nettype none
// Notes on behaviour
// - every register but the port select at 0x4C exists per port; the port select picks the copy.
// - clock counts stable after staying in band 40/80/320/1280 us, select resets 0.
// - four-bit low frequency limit in MHz, reset 5; below it counts as too low.
// - two eight-bit scratch registers without function, reset 0x00 and 0x01.
// - bit 3 sets when header length disagrees with received payload length.
// - bit 2 sets on a payload checksum mismatch.
// - bit 1 sets on a multi-bit header ECC error, never corrected.
// - bit 0 sets on a single-bit header ECC error, which is corrected.
// - error flags are sticky, cleared by reading; bits 7:4 read zero.
// - eight-bit count of errored packets since last read, reset zero, read clears.
// - new frequency captured only when it moves beyond hysteresis; hysteresis resets 3.
module rx_port_csi_error_status #(
    parameter int NUM_PORTS = 2,
    parameter int CNT_W = 17,
    parameter int STAB_CYC2 = `RPCES_STAB2_US * `RPCES_CLK_MHZ,
    parameter int STAB_CYC3 = int'(`RPCES_STAB3_MS * `RPCES_US_PER_MS * `RPCES_CLK_MHZ)
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic [NUM_PORTS*8-1:0] freqMeas,
    input wire logic [NUM_PORTS-1:0] freqMeasValid,
    input wire logic [NUM_PORTS-1:0] errLength,
    input wire logic [NUM_PORTS-1:0] errChecksum,
    input wire logic [NUM_PORTS-1:0] errEccMulti,
    input wire logic [NUM_PORTS-1:0] errEccSingle,
    input wire logic [NUM_PORTS-1:0] pktEnd,
    output logic [NUM_PORTS-1:0] freqStable,
    output logic [NUM_PORTS-1:0] freqTooLow,
    output logic [NUM_PORTS-1:0] headerCorrect
);
    localparam int PORT_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
    localparam int STAB_CYC0 = `RPCES_STAB0_US * `RPCES_CLK_MHZ;
    localparam int STAB_CYC1 = `RPCES_STAB1_US * `RPCES_CLK_MHZ;

    rpces_pkg::rpces_byte_t portSel_reg;
    rpces_pkg::rpces_byte_t clkDetCtl_reg [NUM_PORTS];
    rpces_pkg::rpces_byte_t msgA_reg [NUM_PORTS];
    rpces_pkg::rpces_byte_t msgB_reg [NUM_PORTS];
    rpces_pkg::rpces_byte_t rdData_next;
    logic [PORT_W-1:0] selPort;
    logic selOk;
    logic wrPortSel;
    logic wrClkDet;
    logic wrMsgA;
    logic wrMsgB;
    logic rdFlags;
    logic rdTally;

    rpces_err_if #(.NUM_PORTS(NUM_PORTS)) errBus ();

    // Port index taken from the low bits of the port select register
    always_comb begin
        selPort = portSel_reg[PORT_W-1:0];
        selOk = (32'(selPort) < NUM_PORTS);
    end

    // Write and read decode of the selected port's copy
    always_comb begin
        wrPortSel = regWrEn && (regAddr == `RPCES_ADDR_PORT_SEL);
        wrClkDet = regWrEn && selOk && (regAddr == `RPCES_ADDR_CLK_DET);
        wrMsgA = regWrEn && selOk && (regAddr == `RPCES_ADDR_MSG_A);
        wrMsgB = regWrEn && selOk && (regAddr == `RPCES_ADDR_MSG_B);
        rdFlags = regRdEn && selOk && (regAddr == `RPCES_ADDR_ERR_FLAGS);
        rdTally = regRdEn && selOk && (regAddr == `RPCES_ADDR_ERR_TALLY);
    end

    // Port select register, shared by all ports
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portSel_reg <= `RPCES_RST_PORT_SEL;
        end else if (wrPortSel) begin
            portSel_reg <= regWrData;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : gPort
            logic hit;
            assign hit = (32'(selPort) == p);

            // Clock detect control copy of this port
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    clkDetCtl_reg[p] <= `RPCES_RST_CLK_DET;
                end else if (wrClkDet && hit) begin
                    clkDetCtl_reg[p] <= regWrData;
                end
            end

            // Scratch message copies of this port
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    msgA_reg[p] <= `RPCES_RST_MSG_A;
                    msgB_reg[p] <= `RPCES_RST_MSG_B;
                end else begin
                    if (wrMsgA && hit) begin
                        msgA_reg[p] <= regWrData;
                    end
                    if (wrMsgB && hit) begin
                        msgB_reg[p] <= regWrData;
                    end
                end
            end

            // Error events of this port towards the tracker
            assign errBus.errEvent[p][`RPCES_FLAG_LEN] = errLength[p];
            assign errBus.errEvent[p][`RPCES_FLAG_CKSUM] = errChecksum[p];
            assign errBus.errEvent[p][`RPCES_FLAG_MULTI] = errEccMulti[p];
            assign errBus.errEvent[p][`RPCES_FLAG_SINGLE] = errEccSingle[p];
            assign errBus.pktEnd[p] = pktEnd[p];
            assign errBus.clrFlags[p] = rdFlags && hit;
            assign errBus.clrTally[p] = rdTally && hit;
            assign headerCorrect[p] = errBus.fixHeader[p];

            // Frequency detector of this port
            rpces_freq_detect #(
                .CNT_W(CNT_W),
                .STAB_CYC0(STAB_CYC0),
                .STAB_CYC1(STAB_CYC1),
                .STAB_CYC2(STAB_CYC2),
                .STAB_CYC3(STAB_CYC3)
            ) uFreq (
                .clock(clock),
                .rst_n(rst_n),
                .measured(freqMeas[p*8 +: 8]),
                .measValid(freqMeasValid[p]),
                .hyst(clkDetCtl_reg[p][`RPCES_HYST_MSB:`RPCES_HYST_LSB]),
                .stabSel(clkDetCtl_reg[p][`RPCES_STAB_MSB:`RPCES_STAB_LSB]),
                .lowLimit(clkDetCtl_reg[p][`RPCES_LOW_MSB:`RPCES_LOW_LSB]),
                .stable(freqStable[p]),
                .tooLow(freqTooLow[p])
            );
        end
    endgenerate

    // Error flag and tally storage
    rpces_err_track #(.NUM_PORTS(NUM_PORTS)) uErr (
        .clock(clock),
        .rst_n(rst_n),
        .errBus(errBus)
    );

    // Read data of the selected port; unmapped reads give zero
    always_comb begin
        rdData_next = `RPCES_RD_UNMAPPED;
        if (regAddr == `RPCES_ADDR_PORT_SEL) begin
            rdData_next = portSel_reg;
        end else if (selOk) begin
            unique case (regAddr)
                `RPCES_ADDR_CLK_DET: rdData_next = clkDetCtl_reg[selPort];
                `RPCES_ADDR_MSG_A: rdData_next = msgA_reg[selPort];
                `RPCES_ADDR_MSG_B: rdData_next = msgB_reg[selPort];
                `RPCES_ADDR_ERR_FLAGS: rdData_next = {`RPCES_RSVD_ZERO, errBus.flags[selPort]};
                `RPCES_ADDR_ERR_TALLY: rdData_next = errBus.tally[selPort];
                default: rdData_next = `RPCES_RD_UNMAPPED;
            endcase
        end
    end

    // Registered read answer, one cycle after the read strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            regRdData <= `RPCES_RD_UNMAPPED;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= rdData_next;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/rpces_assertions.sv
// Port-level checks of the receive port error block
`default_nettype none
module rpces_checker #(parameter int NUM_PORTS = 2) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic [NUM_PORTS-1:0] errLength,
    input wire logic [NUM_PORTS-1:0] errChecksum,
    input wire logic [NUM_PORTS-1:0] errEccMulti,
    input wire logic [NUM_PORTS-1:0] errEccSingle,
    input wire logic [NUM_PORTS-1:0] pktEnd,
    input wire logic [NUM_PORTS-1:0] headerCorrect
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Read strobe answered exactly one cycle later
    property p_rd_valid; regRdEn |=> regRdValid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");
    property p_rd_pulse; !regRdEn |=> !regRdValid; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read valid without read");
    property p_unmapped; regRdEn && regAddr == 8'h50 |=> regRdData == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rsvd; regRdEn && regAddr == 8'h7A |=> regRdData[7:4] == 4'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
    // Header fix only for single-bit faults
    property p_hdr; 1'b1 |=> headerCorrect == $past(errEccSingle & ~errEccMulti); endproperty
    a_hdr: assert property (p_hdr) else $error("header fix strobe wrong");
    // Error in all ports shows in the next status read
    property p_len; errLength == '1 ##1 regRdEn && regAddr == 8'h7A |=> regRdData[3]; endproperty
    a_len: assert property (p_len) else $error("length flag missing");
    property p_cksum; errChecksum == '1 ##1 regRdEn && regAddr == 8'h7A |=> regRdData[2]; endproperty
    a_cksum: assert property (p_cksum) else $error("checksum flag missing");
    property p_multi; errEccMulti == '1 ##1 regRdEn && regAddr == 8'h7A |=> regRdData[1]; endproperty
    a_multi: assert property (p_multi) else $error("multi-bit flag missing");
    // Back-to-back reads with no new events return zero
    property p_flag_clr;
        regRdEn && regAddr == 8'h7A && !(|{errLength, errChecksum, errEccMulti, errEccSingle})
        ##1 regRdEn && regAddr == 8'h7A |=> regRdData == 8'h00;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared by read");
    property p_tally_clr;
        regRdEn && regAddr == 8'h7B && !(|pktEnd) ##1 regRdEn && regAddr == 8'h7B |=> regRdData == 8'h00;
    endproperty
    a_tally_clr: assert property (p_tally_clr) else $error("tally not cleared by read");
endmodule
bind rx_port_csi_error_status rpces_checker #(.NUM_PORTS(NUM_PORTS)) chk_u (.clock, .rst_n, .regAddr,
    .regRdEn, .regRdData, .regRdValid, .errLength, .errChecksum, .errEccMulti, .errEccSingle, .pktEnd,
    .headerCorrect);
`default_nettype wire

// ===== bench/rx_port_csi_error_status_bench.sv
// Self-checking bench of the receive port error block
`default_nettype none
module rx_port_csi_error_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, regRdValid;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, addrSel, dataA, dataB;
    logic [15:0] freqMeas = 16'h0000;
    logic [1:0] freqMeasValid = 2'h0, errLength = 2'h0, errChecksum = 2'h0, errEccMulti = 2'h0;
    logic [1:0] errEccSingle = 2'h0, pktEnd = 2'h0, freqStable, freqTooLow, headerCorrect;
    int num_errors = 0, tests_run = 0, pktCount;
    int cycTab[4] = '{2000, 4000, 40, 80};
    rx_port_csi_error_status #(.STAB_CYC2(40), .STAB_CYC3(80)) dut_u (.clock, .rst_n, .regAddr, .regWrEn,
        .regRdEn, .regWrData, .regRdData, .regRdValid, .freqMeas, .freqMeasValid, .errLength, .errChecksum,
        .errEccMulti, .errEccSingle, .pktEnd, .freqStable, .freqTooLow, .headerCorrect);
    // Clock of 20 ns period
    initial forever #10 clock = ~clock;
    function automatic logic [7:0] sat8(input int n);
        return (n > 255) ? 8'hFF : 8'(n);
    endfunction
    task automatic end_of_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        tests_run++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    // One bus and event cycle, every bus and event input set once at the falling edge
    task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
        input logic [3:0] e, input logic [1:0] pm, input logic endp);
        regWrEn = w;
        regRdEn = r;
        regAddr = a;
        regWrData = d;
        errLength = e[3] ? pm : 2'h0;
        errChecksum = e[2] ? pm : 2'h0;
        errEccMulti = e[1] ? pm : 2'h0;
        errEccSingle = e[0] ? pm : 2'h0;
        pktEnd = endp ? pm : 2'h0;
        @(negedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, a, d, 4'h0, 2'h0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cyc(1'b0, 1'b1, a, 8'h00, 4'h0, 2'h0, 1'b0);
        chk($sformatf("read %h", a), {1'b1, e}, {regRdValid, regRdData});
    endtask
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h45ED));
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        // Reset contents of each port copy
        for (int p = 0; p < 2; p++) begin
            wr(8'h4C, 8'(p));
            rd(8'h4C, 8'(p));
            rd(8'h77, 8'hC5);
            rd(8'h78, 8'h00);
            rd(8'h79, 8'h01);
            rd(8'h7A, 8'h00);
            rd(8'h7B, 8'h00);
        end
        // Random contents kept apart per port; status and unmapped writes ignored
        for (int i = 0; i < 20; i++) begin
            addrSel = 8'h77 + 8'($urandom_range(2));
            dataA = 8'($urandom);
            dataB = 8'($urandom);
            wr(8'h4C, 8'h00);
            wr(addrSel, dataA);
            wr(8'h4C, 8'h01);
            wr(addrSel, dataB);
            wr(8'h7A, 8'hFF);
            wr(8'h7B, 8'hFF);
            wr(8'h50, 8'hAA);
            rd(addrSel, dataB);
            wr(8'h4C, 8'h00);
            rd(addrSel, dataA);
            rd(8'h7A, 8'h00);
            rd(8'h7B, 8'h00);
            rd(8'h50, 8'h00);
        end
        // Each error kind sets its own sticky bit in both ports
        for (int k = 0; k < 4; k++) begin
            wr(8'h4C, 8'h00);
            cyc(1'b0, 1'b0, 8'h00, 8'h00, 4'(1 << k), 2'h3, 1'b0);
            chk("header fix", (k == 0) ? 9'h003 : 9'h000, {7'h00, headerCorrect});
            rd(8'h7A, 8'(1 << k));
            rd(8'h7A, 8'h00);
            wr(8'h4C, 8'h01);
            rd(8'h7A, 8'(1 << k));
            rd(8'h7A, 8'h00);
            rd(8'h7B, 8'h00);
        end
        // Errored packets counted in port 1 only, clean ones skipped, count saturates
        for (int i = 0; i < 3; i++) begin
            pktCount = (i == 2) ? 300 : int'($urandom_range(12, 1));
            wr(8'h4C, 8'h01);
            for (int j = 0; j < pktCount; j++) begin
                cyc(1'b0, 1'b0, 8'h00, 8'h00, 4'(1 << (j % 4)), 2'h2, j[0]);
                cyc(1'b0, 1'b0, 8'h00, 8'h00, 4'h0, 2'h2, 1'b1);
            end
            rd(8'h7B, sat8((pktCount + 1) / 2 + pktCount / 2));
            rd(8'h7B, 8'h00);
            wr(8'h4C, 8'h00);
            rd(8'h7B, 8'h00);
        end
        // A packet closing during the clearing read is kept
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 4'h4, 2'h1, 1'b1);
        cyc(1'b0, 1'b1, 8'h7B, 8'h00, 4'h4, 2'h1, 1'b1);
        chk("tally", 9'h101, {regRdValid, regRdData});
        rd(8'h7B, 8'h01);
        // A flag event during the clearing read survives it
        cyc(1'b0, 1'b1, 8'h7A, 8'h00, 4'h1, 2'h1, 1'b0);
        chk("flags", 9'h104, {regRdValid, regRdData});
        rd(8'h7A, 8'h01);
        // Stability time per select, small moves ignored, low limit on held value
        for (int s = 0; s < 4; s++) begin
            wr(8'h77, {2'h3, 2'(s), 4'h5});
            regWrEn = 1'b0;
            freqMeas[7:0] = s[0] ? 8'h40 : 8'h20;
            freqMeasValid = 2'h1;
            repeat (cycTab[s] - 10) @(negedge clock);
            chk("stable", 9'h000, {8'h00, freqStable[0]});
            freqMeas[7:0] = freqMeas[7:0] + 8'h03;
            repeat (20) @(negedge clock);
            chk("stable", 9'h001, {8'h00, freqStable[0]});
            chk("too low", 9'h000, {8'h00, freqTooLow[0]});
        end
        freqMeas[7:0] = 8'h03;
        repeat (5) @(negedge clock);
        chk("too low", 9'h001, {8'h00, freqTooLow[0]});
        chk("stable", 9'h000, {8'h00, freqStable[0]});
        wr(8'h77, 8'h02);
        regWrEn = 1'b0;
        freqMeas[7:0] = 8'h04;
        repeat (5) @(negedge clock);
        chk("too low", 9'h000, {8'h00, freqTooLow[0]});
        chk("stable", 9'h000, {8'h00, freqStable[0]});
        // Port 1 detector settles on its own, untouched by port 0 measurements
        wr(8'h4C, 8'h01);
        wr(8'h77, 8'h05);
        cyc(1'b0, 1'b0, 8'h00, 8'h00, 4'h0, 2'h0, 1'b0);
        chk("frequency flags", 9'h00A, {5'h00, freqStable, freqTooLow});
        end_of_test();
    end
endmodule
`default_nettype wire
